//--- lsw_filter.sv
/*
 * lsw_filter: qualifies a level held for a given number of cycles.
 * Assumes the input is already synchronous to mclk.
 */
`timescale 1ns/10ps
module lsw_filter
    import lsw_pkg::*;
#(
    parameter int CYCLES = 4
) (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic arm,
    input  wire logic level,
    output logic      done
);
    localparam int W = $clog2(CYCLES + 1);

    initial begin
        if (CYCLES < 1) begin
            $error("lsw_filter: CYCLES must be at least 1");
        end
    end

    logic [W-1:0] cnt_r;

    // count while armed and the level holds; restart whenever it breaks
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
        end else if (!arm || !level) begin
            cnt_r <= '0;
        end else if (cnt_r != W'(CYCLES)) begin
            cnt_r <= cnt_r + W'(1);
        end
    end

    assign done = (cnt_r == W'(CYCLES));

    held_full_a: assert property (@(posedge mclk) disable iff (!rstn)
        $rose(done) |-> $past(level) && $past(arm))
        else $error("filter completed without a held level");
endmodule

//--- lsw_host.sv
/*
 * lsw_host: behavioural host controller that drives the enable pin and
 * the transmit pin of the mode and wake controller.
 * Assumes the bench resolves the shared transmit pin from both drivers.
 */
`timescale 1ns/10ps
module lsw_host
    import lsw_pkg::*;
(
    input  wire logic mclk,
    output logic      enable_in,
    output logic      txd_drv
);
    // idle: enable low, transmit high as by its pull-up
    initial begin
        enable_in = 1'b0;
        txd_drv   = 1'b1;
    end

    // change enable just after an edge, never on it
    task automatic set_en(input logic v);
        @(posedge mclk);
        #10 enable_in = v;
    endtask

    // leave normal mode; transmit falls with enable, not after it, and
    // is held past the whole mode-select window so the pick is stable
    task automatic drop_en(input logic tx, input int hold);
        @(posedge mclk);
        #10 txd_drv = tx;
        enable_in = 1'b0;
        repeat (hold) @(posedge mclk);
        #10 txd_drv = 1'b1;
    endtask
endmodule

//--- lsw_mode_ctrl.sv
/*
 * lsw_mode_ctrl: operating-mode and wake-up controller.
 * Assumes all pins are synchronous to mclk, analog comparators deliver
 * clean logic levels, and open-drain pins are resolved outside.
 */
// Operation
// - power-up enters fail-safe, regulator on, reset low 4 ms
// - fail-safe keeps LIN off until enable high, then normal
// - reset output low forces fail-safe from any mode but sleep
// - enable falling with transmit high selects silent mode
// - enable falling with transmit low selects sleep; enable may lead
// - silent: no transmit, regulator on, watchdog/inh off, rx high
// - sleep: no transmit, regulator off, reset and rx low
// - silent/sleep entry ignores LIN, wake and ignition levels
// - regulator undervoltage in silent drives reset low, fail-safe
// - battery below 4 V in silent/sleep returns fail-safe
// - LIN below pre-wake in low power enables receiver, termination
// - filtered LIN dominant then rising edge gives remote wake
// - after remote wake from silent, enable high goes to normal
// - LIN low in normal starts filter; wake on next rising edge
// - filtered wake pin low gives local wake, transmit pulled low
// - filtered ignition high gives local wake, transmit pulled low
// - fail-safe transmit pin shows wake source: high remote
// - wake flags clear when enable high reaches normal mode
// - last wake source stored, shown in fail-safe
// - no mode change while power-up reset is held low
// - watchdog failure drives reset low, forcing fail-safe
`timescale 1ns/10ps
module lsw_mode_ctrl
    import lsw_pkg::*;
#(
    parameter int RESET_CYCLES = RESET_CYC,
    parameter int BUS_CYCLES   = BUS_CYC,
    parameter int WAKE_CYCLES  = WAKE_CYC,
    parameter int IGN_CYCLES   = IGN_CYC,
    parameter int WREARM_CYCLES = WREARM_CYC,
    parameter int IREARM_CYCLES = IREARM_CYC,
    parameter int MSEL_CYCLES  = MSEL_CYC
) (
    input  wire logic mclk,
    input  wire logic rstn,
    input  wire logic supply_ok,
    input  wire logic vcc_undervolt,
    input  wire logic watchdog_fail,
    input  wire logic enable_in,
    input  wire logic txd_in,
    input  wire logic lin_in,
    input  wire logic lin_prewake_threshold,
    input  wire logic wake_in,
    input  wire logic ignition_wake_in,
    output logic      rxd_out,
    output logic      txd_out,
    output logic      txd_oe,
    output logic      txd_strong,
    output logic      lin_drive_dom,
    output logic      lin_rx_enable,
    output logic      lin_term_enable,
    output logic      regulator_on,
    output logic      watchdog_enable,
    output logic      ext_regulator_ctl,
    output logic      reset_out_n,
    output logic      reset_oe,
    output logic [2:0] mode_out
);
    localparam int RW = $clog2(RESET_CYCLES + 1);
    localparam int MW = $clog2(MSEL_CYCLES + 2);

    initial begin
        if (RESET_CYCLES < 1 || MSEL_CYCLES < 1) begin
            $error("lsw_mode_ctrl: counts must be at least 1");
        end
    end

    lsw_mode_t      mode_r;
    logic [RW-1:0]  rst_cnt_r;
    logic [MW-1:0]  msel_cnt_r;
    logic           en_d_r;
    logic           lin_d_r;
    logic           lin_armed_r;
    logic           wake_armed_r;
    logic           ign_armed_r;
    logic           wake_flag_r;
    logic           src_local_r;
    logic           low_power;
    logic           reset_active;
    logic           bus_done;
    logic           wake_done;
    logic           ign_done;
    logic           wrearm_done;
    logic           irearm_done;
    logic           remote_wake;
    logic           local_wake;

    assign low_power    = (mode_r == LSW_SILENT) || (mode_r == LSW_SLEEP);
    assign reset_active = (rst_cnt_r != '0);

    // dominant-level filter for the bus, runs in normal too
    lsw_filter #(.CYCLES(BUS_CYCLES)) u_bus (
        .mclk  (mclk),
        .rstn  (rstn),
        .arm   (1'b1),
        .level (!lin_in),
        .done  (bus_done)
    );
    // wake pin low filter
    lsw_filter #(.CYCLES(WAKE_CYCLES)) u_wake (
        .mclk  (mclk),
        .rstn  (rstn),
        .arm   (wake_armed_r),
        .level (!wake_in),
        .done  (wake_done)
    );
    // ignition high filter
    lsw_filter #(.CYCLES(IGN_CYCLES)) u_ign (
        .mclk  (mclk),
        .rstn  (rstn),
        .arm   (ign_armed_r),
        .level (ignition_wake_in),
        .done  (ign_done)
    );
    // re-arm timers: wake high, ignition low held long enough
    lsw_filter #(.CYCLES(WREARM_CYCLES)) u_wrearm (
        .mclk  (mclk),
        .rstn  (rstn),
        .arm   (1'b1),
        .level (wake_in),
        .done  (wrearm_done)
    );
    lsw_filter #(.CYCLES(IREARM_CYCLES)) u_irearm (
        .mclk  (mclk),
        .rstn  (rstn),
        .arm   (1'b1),
        .level (!ignition_wake_in),
        .done  (irearm_done)
    );

    // previous pin levels for edge detection
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            en_d_r   <= 1'b0;
            lin_d_r  <= 1'b1;
        end else begin
            en_d_r   <= enable_in;
            lin_d_r  <= lin_in;
        end
    end

    // bus dominant qualified; wake fires on the next rising edge
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lin_armed_r <= 1'b0;
        end else if (bus_done) begin
            lin_armed_r <= 1'b1;
        end else if (lin_in && lin_d_r && !low_power) begin
            lin_armed_r <= 1'b0;
        end else if (remote_wake) begin
            lin_armed_r <= 1'b0;
        end
    end

    assign remote_wake = low_power && lin_armed_r
                         && lin_in && !lin_d_r;

    // local wake arming: a fresh edge is needed after the re-arm time
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wake_armed_r <= 1'b0;
            ign_armed_r  <= 1'b0;
        end else begin
            if (wrearm_done) begin
                wake_armed_r <= 1'b1;
            end else if (wake_done) begin
                wake_armed_r <= 1'b0;
            end
            if (irearm_done) begin
                ign_armed_r <= 1'b1;
            end else if (ign_done) begin
                ign_armed_r <= 1'b0;
            end
        end
    end

    // wake pin needs a falling edge start; ignition a rising edge start
    assign local_wake = low_power && ((wake_done && wake_armed_r)
                        || (ign_done && ign_armed_r));

    // reset output timer: power-up, undervoltage and watchdog failure
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_cnt_r <= RW'(RESET_CYCLES);
        end else if (!supply_ok) begin
            rst_cnt_r <= RW'(RESET_CYCLES);
        end else if (watchdog_fail) begin
            rst_cnt_r <= RW'(RESET_CYCLES);
        end else if (vcc_undervolt && mode_r != LSW_SLEEP) begin
            rst_cnt_r <= RW'(RESET_CYCLES);
        end else if (reset_active) begin
            rst_cnt_r <= rst_cnt_r - RW'(1);
        end
    end

    // mode-select window: wait so transmit may follow enable down
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            msel_cnt_r <= '0;
        end else if (mode_r == LSW_MODESEL) begin
            msel_cnt_r <= msel_cnt_r + MW'(1);
        end else begin
            msel_cnt_r <= '0;
        end
    end

    // operating mode sequencer
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= LSW_UNPOWERED;
        end else if (!supply_ok) begin
            if (low_power) begin
                mode_r <= LSW_FAILSAFE;
            end else if (mode_r == LSW_UNPOWERED) begin
                mode_r <= LSW_UNPOWERED;
            end else begin
                mode_r <= LSW_FAILSAFE;
            end
        end else if (reset_active && mode_r != LSW_SLEEP) begin
            mode_r <= LSW_FAILSAFE;
        end else begin
            case (mode_r)
                LSW_UNPOWERED: begin
                    mode_r <= LSW_FAILSAFE;
                end
                LSW_FAILSAFE: begin
                    if (enable_in) begin
                        mode_r <= LSW_NORMAL;
                    end
                end
                LSW_NORMAL: begin
                    if (!enable_in && en_d_r) begin
                        mode_r <= LSW_MODESEL;
                    end
                end
                LSW_MODESEL: begin
                    if (msel_cnt_r == MW'(MSEL_CYCLES)) begin
                        // pin levels of LIN, wake, ignition are not looked at
                        if (txd_in) begin
                            mode_r <= LSW_SILENT;
                        end else begin
                            mode_r <= LSW_SLEEP;
                        end
                    end
                end
                LSW_SILENT, LSW_SLEEP: begin
                    if (remote_wake || local_wake) begin
                        mode_r <= LSW_FAILSAFE;
                    end
                end
                default: begin
                    mode_r <= LSW_FAILSAFE;
                end
            endcase
        end
    end

    // wake flag and stored source; set wins over the clear
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wake_flag_r   <= 1'b0;
            src_local_r   <= 1'b0;
        end else if (remote_wake || local_wake) begin
            wake_flag_r   <= 1'b1;
            src_local_r   <= local_wake;
        end else if (mode_r == LSW_NORMAL && enable_in) begin
            wake_flag_r   <= 1'b0;
        end
    end

    // pin and supply outputs per mode
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rxd_out           <= 1'b1;
            txd_out           <= 1'b1;
            txd_oe            <= 1'b0;
            txd_strong        <= 1'b0;
            lin_drive_dom     <= 1'b0;
            lin_rx_enable     <= 1'b0;
            lin_term_enable   <= 1'b0;
            regulator_on      <= 1'b0;
            watchdog_enable   <= 1'b0;
            ext_regulator_ctl <= 1'b0;
        end else begin
            rxd_out         <= 1'b1;
            txd_out         <= 1'b1;
            txd_oe          <= 1'b0;
            txd_strong      <= 1'b0;
            lin_drive_dom   <= 1'b0;
            lin_rx_enable   <= 1'b0;
            lin_term_enable <= 1'b0;
            regulator_on    <= 1'b1;
            watchdog_enable <= 1'b0;
            ext_regulator_ctl <= 1'b0;
            case (mode_r)
                LSW_FAILSAFE: begin
                    rxd_out <= !wake_flag_r;
                    txd_oe  <= 1'b1;
                    txd_out <= !src_local_r;
                    txd_strong <= src_local_r;
                    lin_rx_enable   <= 1'b1;
                    lin_term_enable <= 1'b1;
                    watchdog_enable <= 1'b1;
                    ext_regulator_ctl <= !reset_active;
                end
                LSW_NORMAL, LSW_MODESEL: begin
                    rxd_out         <= lin_in;
                    // the select window keeps the bus quiet, else a low
                    // transmit pin would feed the bus filter
                    lin_drive_dom   <= !txd_in && (mode_r == LSW_NORMAL);
                    lin_rx_enable   <= 1'b1;
                    lin_term_enable <= 1'b1;
                    watchdog_enable <= 1'b1;
                    ext_regulator_ctl <= !reset_active;
                end
                LSW_SILENT: begin
                    rxd_out <= 1'b1;
                    lin_rx_enable   <= !lin_prewake_threshold;
                    lin_term_enable <= !lin_prewake_threshold;
                end
                LSW_SLEEP: begin
                    rxd_out      <= 1'b0;
                    regulator_on <= 1'b0;
                    lin_rx_enable   <= !lin_prewake_threshold;
                    lin_term_enable <= !lin_prewake_threshold;
                end
                default: begin
                    regulator_on <= 1'b0;
                end
            endcase
        end
    end

    // reset output is open drain: enable drives it low
    assign reset_out_n = !(reset_active || mode_r == LSW_SLEEP);
    assign reset_oe    = !reset_out_n;
    assign mode_out    = mode_r;

    // assertions
    sleep_no_tx_a: assert property (@(posedge mclk) disable iff (!rstn)
        mode_r == LSW_SLEEP |=> !lin_drive_dom && !regulator_on)
        else $error("sleep mode left transmitter or regulator on");
    silent_out_a: assert property (@(posedge mclk) disable iff (!rstn)
        mode_r == LSW_SILENT |=> rxd_out && !watchdog_enable
            && !ext_regulator_ctl && regulator_on)
        else $error("silent mode outputs wrong");
    reset_forces_fs_a: assert property (@(posedge mclk) disable iff (!rstn)
        supply_ok && reset_active && mode_r != LSW_SLEEP
        |=> mode_r == LSW_FAILSAFE)
        else $error("reset did not force fail-safe");
    fs_to_normal_a: assert property (@(posedge mclk) disable iff (!rstn)
        mode_r == LSW_FAILSAFE && enable_in && supply_ok && !reset_active
        |=> mode_r == LSW_NORMAL)
        else $error("enable high did not reach normal");
    silent_sel_a: assert property (@(posedge mclk) disable iff (!rstn)
        mode_r == LSW_MODESEL && msel_cnt_r == MW'(MSEL_CYCLES) && txd_in
        && supply_ok && !reset_active |=> mode_r == LSW_SILENT)
        else $error("silent mode not selected");
    sleep_sel_a: assert property (@(posedge mclk) disable iff (!rstn)
        mode_r == LSW_MODESEL && msel_cnt_r == MW'(MSEL_CYCLES) && !txd_in
        && supply_ok && !reset_active |=> mode_r == LSW_SLEEP)
        else $error("sleep mode not selected");
    batt_drop_a: assert property (@(posedge mclk) disable iff (!rstn)
        low_power && !supply_ok |=> mode_r == LSW_FAILSAFE)
        else $error("battery drop did not give fail-safe");
    wake_src_a: assert property (@(posedge mclk) disable iff (!rstn)
        local_wake |=> mode_r == LSW_FAILSAFE ##1 (txd_oe && !txd_out
            && !rxd_out))
        else $error("local wake not signalled");
    flag_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
        mode_r == LSW_NORMAL && enable_in && !remote_wake && !local_wake
        |=> !wake_flag_r)
        else $error("wake flag not cleared in normal");
    uv_silent_a: assert property (@(posedge mclk) disable iff (!rstn)
        mode_r == LSW_SILENT && vcc_undervolt && supply_ok
        |=> !reset_out_n ##1 mode_r == LSW_FAILSAFE)
        else $error("undervoltage in silent not handled");
    modesel_quiet_a: assert property (@(posedge mclk) disable iff (!rstn)
        mode_r == LSW_MODESEL |=> !lin_drive_dom)
        else $error("bus driven during mode select");
endmodule

//--- lsw_pkg.sv
/*
 * lsw_pkg: constants and types shared by the mode and wake controller
 * of the LIN system basis chip logic.
 * Assumes a single 10 MHz clock (100 ns period) drives all logic.
 */
package lsw_pkg;

    // clock rate in kHz, used to turn times into cycle counts
    localparam int CLK_KHZ        = 10000;

    // times in their own units, figures as documented
    localparam int T_RESET_MS     = 4;    // reset output low time
    localparam int T_BUS_US       = 30;   // bus dominant filter time
    localparam int T_WAKE_US      = 30;   // wake pin low filter time
    localparam int T_IGN_US       = 160;  // ignition_filter_time
    localparam int T_WAKE_REARM_US = 10;  // wake pin high before re-arm
    localparam int T_IGN_REARM_US = 250;  // ignition low before re-arm
    localparam int T_MODE_SEL_NS  = 3200; // enable may lead transmit

    // derived cycle counts: least times round up
    localparam int RESET_CYC  = T_RESET_MS * CLK_KHZ;
    localparam int BUS_CYC    = (T_BUS_US * CLK_KHZ + 999) / 1000;
    localparam int WAKE_CYC   = (T_WAKE_US * CLK_KHZ + 999) / 1000;
    localparam int IGN_CYC    = (T_IGN_US * CLK_KHZ + 999) / 1000;
    localparam int WREARM_CYC = (T_WAKE_REARM_US * CLK_KHZ + 999) / 1000;
    localparam int IREARM_CYC = (T_IGN_REARM_US * CLK_KHZ + 999) / 1000;
    localparam int MSEL_CYC   = (T_MODE_SEL_NS * CLK_KHZ + 999999) / 1000000;

    // operating modes
    typedef enum logic [2:0] {
        LSW_UNPOWERED = 3'b000,
        LSW_FAILSAFE  = 3'b001,
        LSW_NORMAL    = 3'b010,
        LSW_SILENT    = 3'b011,
        LSW_SLEEP     = 3'b100,
        LSW_MODESEL   = 3'b101
    } lsw_mode_t;

endpackage

//--- testbench.sv
/*
 * testbench: directed scenarios for the mode and wake controller.
 * Assumes shortened filter and delay counts; the bus and transmit pins
 * are resolved here from every party that drives them.
 */
`timescale 1ns/10ps
module testbench;
    import lsw_pkg::*;
    localparam int RST_N = 20;
    localparam int BUS_N = 5;
    localparam int MSEL_N = MSEL_CYC;
    logic       mclk, rstn, supply_ok, vcc_undervolt, watchdog_fail;
    logic       bus_lvl, wake_in, ignition_wake_in;
    logic       rxd_out, txd_out, txd_oe, txd_strong, lin_drive_dom;
    logic       lin_rx_enable, lin_term_enable, regulator_on;
    logic       watchdog_enable, ext_regulator_ctl, reset_out_n, reset_oe;
    logic [2:0] mode_out;
    wire logic  enable_in, txd_drv, txd_pin, lin_in;
    int         error_cnt, num_checks;

    // bus is wired-and of the far nodes and our own dominant drive
    assign lin_in  = bus_lvl & ~lin_drive_dom;
    assign txd_pin = txd_oe ? txd_out : txd_drv;

    lsw_host host_u (.mclk(mclk), .enable_in(enable_in), .txd_drv(txd_drv));

    // wake re-arm and select window run at their default counts
    lsw_mode_ctrl #(.RESET_CYCLES(RST_N), .BUS_CYCLES(BUS_N),
        .WAKE_CYCLES(5), .IGN_CYCLES(8), .IREARM_CYCLES(4)) dut_u (
        .mclk(mclk), .rstn(rstn), .supply_ok(supply_ok),
        .vcc_undervolt(vcc_undervolt), .watchdog_fail(watchdog_fail),
        .enable_in(enable_in), .txd_in(txd_pin), .lin_in(lin_in),
        .lin_prewake_threshold(lin_in), .wake_in(wake_in),
        .ignition_wake_in(ignition_wake_in), .rxd_out(rxd_out),
        .txd_out(txd_out), .txd_oe(txd_oe), .txd_strong(txd_strong),
        .lin_drive_dom(lin_drive_dom), .lin_rx_enable(lin_rx_enable),
        .lin_term_enable(lin_term_enable), .regulator_on(regulator_on),
        .watchdog_enable(watchdog_enable),
        .ext_regulator_ctl(ext_regulator_ctl), .reset_out_n(reset_out_n),
        .reset_oe(reset_oe), .mode_out(mode_out));

    // 100 ns period clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic ck(input logic [2:0] seen, input logic [2:0] exp,
                      input string what);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: %s seen %b expected %b", $time, what,
                     seen, exp);
        end
    endtask

    // bounded wait for a mode, then let the outputs follow it
    task automatic wait_mode(input lsw_mode_t m);
        int n;
        for (n = 0; n < 200 && mode_out !== m; n++) begin
            @(posedge mclk);
            #1;
        end
        if (n == 200) begin
            error_cnt++;
            $display("Error at %0t: mode %s never reached", $time, m.name());
            conclude();
        end
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic into_low(input logic tx, input lsw_mode_t m);
        host_u.drop_en(tx, MSEL_N + 4);
        wait_mode(m);
    endtask

    task automatic go_normal();
        host_u.set_en(1'b1);
        wait_mode(LSW_NORMAL);
        ck(reset_out_n, 1'b1, "reset after normal");
    endtask

    // enable held high through power-up must not cut the reset short
    task automatic t_power();
        int low;
        low = 0;
        host_u.set_en(1'b1);
        rstn = 1'b1;
        repeat (2) @(posedge mclk);
        #1 ck(mode_out, LSW_FAILSAFE, "power-up mode");
        ck(regulator_on, 1'b1, "power-up regulator");
        ck(lin_drive_dom, 1'b0, "fail-safe bus");
        for (int n = 0; n < 100 && mode_out !== LSW_NORMAL; n++) begin
            if (reset_out_n === 1'b0)
                low++;
            @(posedge mclk);
            #1;
        end
        ck(low >= RST_N - 2, 1'b1, "reset low length");
        ck(mode_out, LSW_NORMAL, "normal after reset");
        $display("test power-up done");
    endtask

    // silent entry, then a remote wake back to normal
    task automatic t_remote();
        into_low(1'b1, LSW_SILENT);
        ck({rxd_out, watchdog_enable, ext_regulator_ctl}, 3'b100,
           "silent pins");
        ck({regulator_on, lin_drive_dom}, 2'b10, "silent supply");
        #9 bus_lvl = 1'b0;
        repeat (BUS_N + 3) @(posedge mclk);
        #1 ck({lin_rx_enable, lin_term_enable}, 2'b11, "prewake");
        #9 bus_lvl = 1'b1;
        wait_mode(LSW_FAILSAFE);
        ck({rxd_out, txd_oe, txd_out}, 3'b011, "remote flags");
        ck({txd_strong, ext_regulator_ctl}, 2'b01, "remote drive");
        ck(regulator_on, 1'b1, "remote regulator");
        go_normal();
        ck({rxd_out, txd_oe}, 2'b10, "flags cleared");
        $display("test remote wake done");
    endtask

    // bus low in normal pre-arms the filter; silent entry while low
    task automatic t_prearm();
        #9 bus_lvl = 1'b0;
        repeat (BUS_N + 2) @(posedge mclk);
        into_low(1'b1, LSW_SILENT);
        #9 bus_lvl = 1'b1;
        wait_mode(LSW_FAILSAFE);
        ck(txd_out, 1'b1, "prearm source");
        go_normal();
        $display("test pre-armed wake done");
    endtask

    // sleep entry then local wake from the wake pin, or silent entry then from ignition
    task automatic t_local(input logic ign);
        into_low(ign, ign ? LSW_SILENT : LSW_SLEEP);
        if (!ign) begin
            ck({regulator_on, reset_out_n, rxd_out}, 3'b000,
               "sleep pins");
            ck(lin_term_enable, 1'b0, "sleep termination");
        end
        #9 wake_in = ign;
        ignition_wake_in = ign;
        wait_mode(LSW_FAILSAFE);
        ck({rxd_out, txd_oe, txd_out}, 3'b010, "local flags");
        ck(txd_strong, 1'b1, "local pull-down");
        #9 wake_in = 1'b1;
        ignition_wake_in = 1'b0;
        repeat (3) @(posedge mclk);
        #1 ck(txd_out, 1'b0, "source stored");
        go_normal();
        $display("test local wake done");
    endtask

    // undervoltage in silent, battery drop in sleep, watchdog in normal
    task automatic t_fault(input int k);
        if (k < 2)
            into_low(k == 0, k == 0 ? LSW_SILENT : LSW_SLEEP);
        #9 vcc_undervolt = (k == 0);
        supply_ok = (k != 1);
        watchdog_fail = (k == 2);
        repeat (3) @(posedge mclk);
        #1 ck(mode_out, LSW_FAILSAFE, "fault mode");
        ck({reset_out_n, reset_oe}, 2'b01, "fault reset");
        #9 {vcc_undervolt, watchdog_fail, supply_ok} = 3'b001;
        if (k == 1)
            wait_mode(LSW_FAILSAFE);
        go_normal();
        $display("test fault %0d done", k);
    endtask

    // all inputs valued at time zero, reset held for 11 cycles
    initial begin
        error_cnt = 0;
        num_checks = 0;
        {rstn, vcc_undervolt, watchdog_fail, ignition_wake_in} = 4'h0;
        {supply_ok, bus_lvl, wake_in} = 3'b111;
        repeat (10) @(posedge mclk);
        t_power();
        t_remote();
        t_prearm();
        t_local(1'b0);
        t_local(1'b1);
        for (int k = 0; k < 3; k++)
            t_fault(k);
        conclude();
    end
endmodule
